/* pkg/cmi_pkg.sv */
/*
  cmi_pkg: constants and carrier types for the core memory map decoder
  and interrupt entry/return sequencer.
  assumes: single cpu clock, synchronous active-low reset.
*/
`default_nettype none
package cmi_pkg;
  // ************************************************************
  // data space map
  // ************************************************************
  localparam int unsigned DATA_AW          = 16;
  localparam logic [15:0] REGFILE_FIRST    = 16'h0000;
  localparam logic [15:0] REGFILE_LAST     = 16'h001f;
  localparam logic [15:0] STD_IO_FIRST     = 16'h0020;
  localparam logic [15:0] STD_IO_LAST      = 16'h005f;
  localparam logic [15:0] EXT_IO_FIRST     = 16'h0060;
  localparam logic [15:0] EXT_IO_LAST      = 16'h00ff;
  localparam logic [15:0] SRAM_FIRST_ADDRESS = 16'h0100;
  localparam logic [15:0] SRAM_LAST_ADDRESS  = 16'h02ff;
  localparam int unsigned SRAM_BYTES       = 512;
  localparam int unsigned SRAM_AW          = 9;
  localparam logic [5:0]  DISP_MAX         = 6'h3f;
  // ************************************************************
  // program and nvm spaces
  // ************************************************************
  localparam logic [15:0] FLASH_BYTE_LAST  = 16'h3fff;
  localparam logic [15:0] FLASH_WORD_LAST  = 16'h1fff;
  localparam int unsigned FLASH_WORD_W     = 16;
  localparam int unsigned NVM_BYTE_CAPACITY = 512;
  localparam logic [15:0] NVM_LAST_ADDRESS = 16'h01ff;
  // ************************************************************
  // timing
  // ************************************************************
  localparam logic [2:0]  ENTRY_CYCLES     = 3'h4;
  localparam logic [2:0]  WAKE_EXTRA       = 3'h4;
  localparam logic [2:0]  RETURN_CYCLES    = 3'h4;
  localparam logic [2:0]  VECTOR_JMP_CYCLES = 3'h3;
  localparam logic [1:0]  SRAM_CYCLES      = 2'h2;
  localparam logic [15:0] RET_ADDR_BYTES   = 16'h0002;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    CMI_REGION_REGFILE = 4'h1,
    CMI_REGION_STD_IO  = 4'h2,
    CMI_REGION_EXT_IO  = 4'h4,
    CMI_REGION_SRAM    = 4'h8,
    CMI_REGION_NONE    = 4'h0
  } cmi_region_t;

  typedef enum logic [2:0] {
    CMI_MODE_DIRECT = 3'h0,
    CMI_MODE_IND    = 3'h1,
    CMI_MODE_DISP   = 3'h2,
    CMI_MODE_PREDEC = 3'h3,
    CMI_MODE_POSTINC = 3'h4
  } cmi_amode_t;

  typedef enum logic [1:0] {
    CMI_PTR_X = 2'h0,
    CMI_PTR_Y = 2'h1,
    CMI_PTR_Z = 2'h2
  } cmi_ptr_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       io_short;
    cmi_amode_t mode;
    cmi_ptr_t   ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cmi_dreq_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    cmi_region_t region;
  } cmi_dsel_t;
endpackage : cmi_pkg
`default_nettype wire

/* rtl/cmi_sram.sv */
/*
  cmi_sram: internal data byte memory, registered read data.
  assumes: caller presents a valid in-range index.
*/
`timescale 1ns/1ns
`default_nettype none
module cmi_sram #(
  parameter int unsigned DEPTH = 512,
  parameter int unsigned AW    = 9
) (
  // clock
  input  wire logic          i_clock,
  // access
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic [7:0]         o_rdata
);
  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge i_clock)
  begin
    if (i_we)
    begin
      mem_r[i_addr] <= i_wdata;
    end
    o_rdata <= mem_r[i_addr];
  end
endmodule : cmi_sram
`default_nettype wire

/* rtl/cmi_addr_gen.sv */
/*
  cmi_addr_gen: effective address and pointer update for data accesses.
  assumes: pointer values supplied by the register file.
*/
`timescale 1ns/1ns
`default_nettype none
module cmi_addr_gen
  import cmi_pkg::*;
(
  // request
  input  wire cmi_pkg::cmi_dreq_t i_req,
  input  wire logic [15:0]        i_ptr_val,
  // result
  output logic [15:0]             o_ea,
  output logic [15:0]             o_ptr_new,
  output logic                    o_ptr_we
);
  always_comb
  begin
    o_ea      = i_req.addr;
    o_ptr_new = i_ptr_val;
    o_ptr_we  = 1'b0;
    if (i_req.io_short)
    begin
      o_ea = STD_IO_FIRST + {10'h000, i_req.addr[5:0]};
    end
    else
    begin
      case (i_req.mode)
        CMI_MODE_IND:
        begin
          o_ea = i_ptr_val;
        end
        CMI_MODE_DISP:
        begin
          o_ea = i_ptr_val + {10'h000, i_req.disp & DISP_MAX};
        end
        CMI_MODE_PREDEC:
        begin
          o_ea      = i_ptr_val - 16'h0001;
          o_ptr_new = o_ea;
          o_ptr_we  = i_req.valid;
        end
        CMI_MODE_POSTINC:
        begin
          o_ea      = i_ptr_val;
          o_ptr_new = i_ptr_val + 16'h0001;
          o_ptr_we  = i_req.valid;
        end
        default:
        begin
          o_ea = i_req.addr;
        end
      endcase
    end
  end
endmodule : cmi_addr_gen
`default_nettype wire

/* rtl/cmi_core_ctl.sv */
/*
  cmi_core_ctl: data-space decode with sram access, and the interrupt
  entry / return cycle sequencer of the core.
  assumes: the execute stage reports instruction boundaries and the
  instruction kind; a separate peripheral fabric answers i/o regions.
*/
// Contract
// - interrupt entry four cycles, pushing pc
// - vector jump takes three cycles
// - finish multi-cycle instruction before entry
// - wake from sleep adds four cycles
// - return four cycles, pop, sp+2, set enable
// - one instruction after enable before service
// - 0x0000-0x001f select working registers
// - 0x0020-0x005f select standard i/o
// - 0x0060-0x00ff select extended i/o
// - 0x0100-0x02ff select internal sram
// - extended i/o only via load/store
// - displacement adds up to 63
// - pre-decrement/post-increment update pointer
// - direct addressing reaches whole data space
// - sram access takes two cycles
// - flash 16-bit words, ends 0x3fff/0x1fff
// - no boot section, store anywhere
// - nvm separate space ending 0x01ff
// - accepting interrupt clears global enable
// - return address push lowers sp two
// - lower vector number wins priority
// - one instruction after return before service
`timescale 1ns/1ns
`default_nettype none
module cmi_core_ctl
  import cmi_pkg::*;
#(
  parameter int unsigned NIRQ = 8
) (
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_resetn,
  // execute stage
  input  wire logic                i_insn_done,
  input  wire logic                i_sleeping,
  input  wire logic                i_wake_ready,
  input  wire logic                i_sei_exec,
  input  wire logic                i_cli_exec,
  input  wire logic                i_reti_req,
  input  wire logic [15:0]         i_pc,
  input  wire logic [15:0]         i_sp,
  // interrupt requests, bit 0 lowest vector
  input  wire logic [NIRQ-1:0]     i_irq,
  // data access
  input  wire cmi_pkg::cmi_dreq_t  i_dreq,
  input  wire logic [15:0]         i_ptr_val,
  // nvm and flash address checks
  input  wire logic [15:0]         i_nvm_addr,
  input  wire logic [15:0]         i_flash_word_addr,
  // sequencer outputs
  output logic                     o_gie,
  output logic                     o_stall,
  output logic                     o_irq_ack,
  output logic [NIRQ-1:0]          o_irq_ack_vec,
  output logic                     o_vector_fetch,
  output logic                     o_push,
  output logic                     o_pop,
  output logic [15:0]              o_sp_next,
  output logic                     o_sp_we,
  output logic [15:0]              o_stack_addr,
  // data outputs
  output cmi_pkg::cmi_dsel_t       o_dsel,
  output logic                     o_ptr_we,
  output logic [15:0]              o_ptr_new,
  output logic                     o_sram_busy,
  output logic                     o_sram_rvalid,
  output logic [7:0]               o_sram_rdata,
  output logic                     o_nvm_addr_ok,
  output logic                     o_flash_addr_ok,
  output logic                     o_store_pm_ok
);
  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic cmi_region_t cmi_decode(input logic [15:0] a);
    if (a <= REGFILE_LAST)
      cmi_decode = CMI_REGION_REGFILE;
    else if (a <= STD_IO_LAST)
      cmi_decode = CMI_REGION_STD_IO;
    else if (a <= EXT_IO_LAST)
      cmi_decode = CMI_REGION_EXT_IO;
    else if (a <= SRAM_LAST_ADDRESS)
      cmi_decode = CMI_REGION_SRAM;
    else
      cmi_decode = CMI_REGION_NONE;
  endfunction : cmi_decode

  function automatic logic [NIRQ-1:0] cmi_pick(input logic [NIRQ-1:0] r);
    logic [NIRQ-1:0] g;
    g = '0;
    for (int i = NIRQ - 1; i >= 0; i--)
      if (r[i])
        g = NIRQ'(1) << i;
    cmi_pick = g;
  endfunction : cmi_pick

  // ************************************************************
  // data space decode and sram
  // ************************************************************
  logic [15:0]  ea;
  cmi_region_t  region;
  logic         sram_hit;
  logic         sram_ph_r;
  logic [7:0]   sram_q;

  cmi_addr_gen u_agen (
    .i_req     (i_dreq),
    .i_ptr_val (i_ptr_val),
    .o_ea      (ea),
    .o_ptr_new (o_ptr_new),
    .o_ptr_we  (o_ptr_we)
  );

  assign region   = cmi_decode(ea);
  assign sram_hit = i_dreq.valid && (region == CMI_REGION_SRAM) && !sram_ph_r;

  // short i/o forms never leave the standard window
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      o_dsel <= '0;
    else
    begin
      o_dsel.valid  <= i_dreq.valid;
      o_dsel.addr   <= ea;
      o_dsel.region <= region;
    end
  end

  cmi_sram #(
    .DEPTH (SRAM_BYTES),
    .AW    (SRAM_AW)
  ) u_sram (
    .i_clock (i_clock),
    .i_we    (sram_hit && i_dreq.write),
    .i_addr  (SRAM_AW'(ea - SRAM_FIRST_ADDRESS)),
    .i_wdata (i_dreq.wdata),
    .o_rdata (sram_q)
  );

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      sram_ph_r <= 1'b0;
    else
      sram_ph_r <= sram_hit;
  end
  assign o_sram_busy   = sram_hit;
  assign o_sram_rvalid = sram_ph_r;
  assign o_sram_rdata  = sram_q;

  assign o_nvm_addr_ok   = (i_nvm_addr <= NVM_LAST_ADDRESS);
  assign o_flash_addr_ok = (i_flash_word_addr <= FLASH_WORD_LAST);
  // store to program memory from anywhere
  assign o_store_pm_ok   = o_flash_addr_ok;

  // ************************************************************
  // interrupt sequencer
  // ************************************************************
  typedef enum logic [4:0] {
    CMI_RUN   = 5'h01,
    CMI_WAKE  = 5'h02,
    CMI_ENTRY = 5'h04,
    CMI_JUMP  = 5'h08,
    CMI_RET   = 5'h10
  } cmi_state_t;

  cmi_state_t      state_r;
  cmi_state_t      state_nxt;
  logic [2:0]      cnt_r;
  logic [2:0]      cnt_nxt;
  logic            gie_r;
  logic            hold_r;
  logic [15:0]     sp_r;
  logic [NIRQ-1:0] grant;
  logic            take;

  // hold_r blocks service for one instruction
  assign grant = cmi_pick(i_irq);
  assign take  = gie_r && !hold_r && (|i_irq) && !i_cli_exec &&
                 (i_insn_done || (i_sleeping && i_wake_ready));

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      CMI_RUN:
      begin
        if (take && i_sleeping)
        begin
          state_nxt = CMI_WAKE;
          cnt_nxt   = WAKE_EXTRA - 3'h1;
        end
        else if (take)
        begin
          state_nxt = CMI_ENTRY;
          cnt_nxt   = ENTRY_CYCLES - 3'h1;
        end
        else if (i_reti_req && i_insn_done)
        begin
          state_nxt = CMI_RET;
          cnt_nxt   = RETURN_CYCLES - 3'h1;
        end
      end
      CMI_WAKE:
      begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h0)
        begin
          state_nxt = CMI_ENTRY;
          cnt_nxt   = ENTRY_CYCLES - 3'h1;
        end
      end
      CMI_ENTRY:
      begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h0)
        begin
          state_nxt = CMI_JUMP;
          cnt_nxt   = VECTOR_JMP_CYCLES - 3'h1;
        end
      end
      CMI_JUMP:
      begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h0)
          state_nxt = CMI_RUN;
      end
      CMI_RET:
      begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h0)
          state_nxt = CMI_RUN;
      end
      default:
      begin
        state_nxt = CMI_RUN;
        cnt_nxt   = 3'h0;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      state_r <= CMI_RUN;
      cnt_r   <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // global enable: entry clears, return and sei set
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      gie_r <= 1'b0;
    else if (state_r == CMI_RUN && take)
      gie_r <= 1'b0;
    // return sets enable on its last cycle
    else if (state_r == CMI_RET && cnt_r == 3'h0)
      gie_r <= 1'b1;
    else if (i_cli_exec)
      gie_r <= 1'b0;
    else if (i_sei_exec)
      gie_r <= 1'b1;
  end

  // one-instruction shadow after sei or return
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      hold_r <= 1'b0;
    else if (i_sei_exec || (state_r == CMI_RET && cnt_r == 3'h0))
      hold_r <= 1'b1;
    else if (i_insn_done && state_r == CMI_RUN)
      hold_r <= 1'b0;
  end

  // stack pointer tracking: two bytes per push or pop
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      sp_r <= SRAM_LAST_ADDRESS;
    else if (state_r == CMI_RUN && state_nxt != CMI_RUN)
      sp_r <= i_sp;
    else if (state_r == CMI_ENTRY && cnt_r == 3'h0)
      sp_r <= sp_r - RET_ADDR_BYTES;
    else if (state_r == CMI_RET && cnt_r == 3'h0)
      sp_r <= sp_r + RET_ADDR_BYTES;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
      o_irq_ack_vec <= '0;
    else if (state_r == CMI_RUN && take)
      o_irq_ack_vec <= grant;
  end

  assign o_gie          = gie_r;
  assign o_stall        = (state_r != CMI_RUN);
  assign o_irq_ack      = (state_r == CMI_RUN) && take;
  // pc pushed inside the entry window
  assign o_push         = (state_r == CMI_ENTRY) && (cnt_r >= 3'h2);
  assign o_pop          = (state_r == CMI_RET) && (cnt_r >= 3'h2);
  // push writes at and below sp, so pop reads sp+1 then sp+2
  assign o_stack_addr   = o_push ? (sp_r - {15'h0000, cnt_r == 3'h2})
                                 : (sp_r + {13'h0000, 3'h4 - cnt_r});
  assign o_vector_fetch = (state_r == CMI_ENTRY) && (cnt_r == 3'h0);
  assign o_sp_we        = ((state_r == CMI_ENTRY) || (state_r == CMI_RET)) &&
                          (cnt_r == 3'h0);
  assign o_sp_next      = (state_r == CMI_ENTRY) ? sp_r - RET_ADDR_BYTES
                                                 : sp_r + RET_ADDR_BYTES;

  // ************************************************************
  // checks
  // ************************************************************
  sequence entry_run_s;
    state_r == CMI_ENTRY [*4];
  endsequence

  entry_len_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(state_r == CMI_ENTRY) |-> entry_run_s ##1 state_r == CMI_JUMP)
    else $error("entry not four cycles");
  jump_len_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(state_r == CMI_JUMP) |-> (state_r == CMI_JUMP) [*3] ##1 state_r == CMI_RUN)
    else $error("vector jump not three cycles");
  wake_len_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(state_r == CMI_WAKE) |-> (state_r == CMI_WAKE) [*4] ##1 entry_run_s)
    else $error("wake extension not four cycles");
  ret_len_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(state_r == CMI_RET) |-> (state_r == CMI_RET) [*4] ##1 gie_r)
    else $error("return not four cycles or enable not set");
  gie_clr_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_irq_ack |=> !gie_r)
    else $error("enable not cleared on accept");
  sp_push_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_r == CMI_ENTRY && cnt_r == 3'h0) |=> sp_r == $past(sp_r) - RET_ADDR_BYTES)
    else $error("push did not lower sp by two");
  sei_shadow_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_sei_exec |=> !o_irq_ack)
    else $error("interrupt taken right after enable");
  sram_two_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_sram_busy |=> o_sram_rvalid && !o_sram_busy)
    else $error("sram access not two cycles");
  prio_low_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_irq_ack && i_irq[0] |=> o_irq_ack_vec[0])
    else $error("lowest vector did not win");
endmodule : cmi_core_ctl
`default_nettype wire

/* test/tb.sv */
/*
  tb: self-checking bench for cmi_core_ctl: data decode, sram timing,
  interrupt entry, return and wake sequencing, address range checks.
  assumes: inputs change at the falling edge, outputs read 1 ns later.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cmi_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic        i_clock, i_resetn, i_insn_done, i_sleeping, i_wake_ready;
  logic        i_sei_exec, i_cli_exec, i_reti_req;
  logic [15:0] i_pc, i_sp, i_ptr_val, i_nvm_addr, i_flash_word_addr;
  logic [7:0]  i_irq;
  cmi_dreq_t   i_dreq;
  logic        o_gie, o_stall, o_irq_ack, o_vector_fetch, o_push, o_pop, o_sp_we;
  logic        o_ptr_we, o_sram_busy, o_sram_rvalid;
  logic        o_nvm_addr_ok, o_flash_addr_ok, o_store_pm_ok;
  logic [7:0]  o_irq_ack_vec, o_sram_rdata;
  logic [15:0] o_sp_next, o_stack_addr, o_ptr_new;
  cmi_dsel_t   o_dsel;
  int          n_mismatch, tests_run, s, x, v;

  cmi_core_ctl #(.NIRQ(8)) dut_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_insn_done(i_insn_done),
    .i_sleeping(i_sleeping), .i_wake_ready(i_wake_ready), .i_sei_exec(i_sei_exec),
    .i_cli_exec(i_cli_exec), .i_reti_req(i_reti_req), .i_pc(i_pc), .i_sp(i_sp),
    .i_irq(i_irq), .i_dreq(i_dreq), .i_ptr_val(i_ptr_val), .i_nvm_addr(i_nvm_addr),
    .i_flash_word_addr(i_flash_word_addr), .o_gie(o_gie), .o_stall(o_stall),
    .o_irq_ack(o_irq_ack), .o_irq_ack_vec(o_irq_ack_vec),
    .o_vector_fetch(o_vector_fetch), .o_push(o_push), .o_pop(o_pop),
    .o_sp_next(o_sp_next), .o_sp_we(o_sp_we), .o_stack_addr(o_stack_addr),
    .o_dsel(o_dsel), .o_ptr_we(o_ptr_we), .o_ptr_new(o_ptr_new),
    .o_sram_busy(o_sram_busy), .o_sram_rvalid(o_sram_rvalid),
    .o_sram_rdata(o_sram_rdata), .o_nvm_addr_ok(o_nvm_addr_ok),
    .o_flash_addr_ok(o_flash_addr_ok), .o_store_pm_ok(o_store_pm_ok)
  );
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : chk

  function automatic cmi_dreq_t mk(input logic [15:0] a, input cmi_amode_t m,
                                   input cmi_ptr_t p, input logic [5:0] d,
                                   input logic w, input logic [7:0] wd, input logic ios);
    mk          = '0;
    mk.valid    = 1'b1;
    mk.addr     = a;
    mk.mode     = m;
    mk.ptr      = p;
    mk.disp     = d;
    mk.write    = w;
    mk.wdata    = wd;
    mk.io_short = ios;
  endfunction : mk

  task automatic req(input cmi_dreq_t r, input logic [15:0] pv);
    @(negedge i_clock);
    i_dreq    = r;
    i_ptr_val = pv;
    #1;
  endtask : req

  // request lasts one cycle, so the sram never sees a held request
  task automatic rel;
    @(negedge i_clock);
    i_dreq.valid = 1'b0;
    #1;
  endtask : rel

  task automatic pulse(input logic sei, input logic reti);
    @(negedge i_clock);
    i_insn_done = 1'b1;
    i_sei_exec  = sei;
    i_reti_req  = reti;
    #1;
  endtask : pulse

  task automatic quiet;
    @(negedge i_clock);
    i_insn_done = 1'b0;
    i_sei_exec  = 1'b0;
    i_reti_req  = 1'b0;
    #1;
  endtask : quiet

  // counts stall and stack transfer cycles from the cycle after the grant
  task automatic watch(input int n, input logic [15:0] spx,
                       output int stl, output int xf, output int vf);
    stl = 0;
    xf  = 0;
    vf  = 0;
    for (int k = 1; k <= n; k++)
    begin
      if (o_stall === 1'b1) stl++;
      if (o_push === 1'b1 || o_pop === 1'b1) xf++;
      if (o_vector_fetch === 1'b1) vf = k;
      if (o_sp_we === 1'b1) chk(o_sp_next === spx, "sp step");
      @(negedge i_clock);
      #1;
    end
  endtask : watch
  // ************************************************************
  // scenarios
  // ************************************************************
  logic [15:0] dec_a [10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060,
                              16'h00ff, 16'h0100, 16'h02ff, 16'h0300, 16'hffff};
  cmi_region_t dec_r [10] = '{CMI_REGION_REGFILE, CMI_REGION_REGFILE, CMI_REGION_STD_IO,
                              CMI_REGION_STD_IO, CMI_REGION_EXT_IO, CMI_REGION_EXT_IO,
                              CMI_REGION_SRAM, CMI_REGION_SRAM, CMI_REGION_NONE,
                              CMI_REGION_NONE};

  task automatic t_decode;
    for (int k = 0; k < 10; k++)
    begin
      req(mk(dec_a[k], CMI_MODE_DIRECT, CMI_PTR_X, 6'h00, 1'b0, 8'h00, 1'b0), 16'h0000);
      rel();
      chk(o_dsel.valid === 1'b1, "select valid");
      chk(o_dsel.region === dec_r[k], "region");
      chk(o_dsel.addr === dec_a[k], "direct addr");
    end
  endtask : t_decode

  task automatic t_modes;
    req(mk(16'h0000, CMI_MODE_DISP, CMI_PTR_Y, 6'h3f, 1'b0, 8'h00, 1'b0), 16'h0100);
    rel();
    chk(o_dsel.addr === 16'h013f, "displacement");
    req(mk(16'h0000, CMI_MODE_PREDEC, CMI_PTR_X, 6'h00, 1'b0, 8'h00, 1'b0), 16'h0200);
    chk(o_ptr_we === 1'b1 && o_ptr_new === 16'h01ff, "pre-decrement ptr");
    rel();
    chk(o_dsel.addr === 16'h01ff, "pre-decrement addr");
    req(mk(16'h0000, CMI_MODE_POSTINC, CMI_PTR_Z, 6'h00, 1'b0, 8'h00, 1'b0), 16'h0200);
    chk(o_ptr_we === 1'b1 && o_ptr_new === 16'h0201, "post-increment ptr");
    rel();
    chk(o_dsel.addr === 16'h0200, "post-increment addr");
    req(mk(16'h00a0, CMI_MODE_DIRECT, CMI_PTR_X, 6'h00, 1'b0, 8'h00, 1'b1), 16'h0000);
    rel();
    chk(o_dsel.addr === 16'h0040 && o_dsel.region === CMI_REGION_STD_IO, "short i/o");
  endtask : t_modes

  task automatic t_sram;
    req(mk(16'h0155, CMI_MODE_DIRECT, CMI_PTR_X, 6'h00, 1'b1, 8'ha5, 1'b0), 16'h0000);
    chk(o_sram_busy === 1'b1, "sram write busy");
    rel();
    // 0x0355 gives the same low index bits as 0x0155; only the region decode keeps its write out of sram
    req(mk(16'h0355, CMI_MODE_DIRECT, CMI_PTR_X, 6'h00, 1'b1, 8'h3c, 1'b0), 16'h0000);
    rel();
    req(mk(16'h0155, CMI_MODE_DIRECT, CMI_PTR_X, 6'h00, 1'b0, 8'h00, 1'b0), 16'h0000);
    chk(o_sram_busy === 1'b1 && o_sram_rvalid === 1'b0, "sram read c0");
    rel();
    chk(o_sram_rvalid === 1'b1 && o_sram_rdata === 8'ha5, "sram read c1");
  endtask : t_sram

  task automatic t_entry;
    i_irq = 8'h28;
    pulse(1'b1, 1'b0);
    chk(o_irq_ack === 1'b0, "ack while disabled");
    pulse(1'b0, 1'b0);
    chk(o_gie === 1'b1 && o_irq_ack === 1'b0, "enable shadow");
    repeat (3)
    begin
      quiet();
      chk(o_irq_ack === 1'b0, "ack mid-instruction");
    end
    i_pc = 16'h1234;
    i_sp = 16'h02ff;
    pulse(1'b0, 1'b0);
    chk(o_irq_ack === 1'b1, "ack at boundary");
    quiet();
    i_irq = 8'h00;
    chk(o_gie === 1'b0 && o_irq_ack_vec === 8'h08, "grant");
    chk(o_push === 1'b1 && o_stack_addr === 16'h02ff, "first push addr");
    watch(10, 16'h02fd, s, x, v);
    chk(s == 7 && v == 4, "entry cycles");
    chk(x == 2, "pc bytes pushed");
  endtask : t_entry

  task automatic t_return;
    i_irq = 8'h01;
    i_sp  = 16'h02fd;
    pulse(1'b0, 1'b1);
    chk(o_irq_ack === 1'b0, "ack in handler");
    quiet();
    chk(o_pop === 1'b1 && o_stack_addr === 16'h02fe, "first pop addr");
    watch(6, 16'h02ff, s, x, v);
    chk(s == 4 && x == 2, "return cycles");
    chk(o_gie === 1'b1, "enable restored");
    i_sp = 16'h02ff;
    pulse(1'b0, 1'b0);
    chk(o_irq_ack === 1'b0, "return shadow");
    pulse(1'b0, 1'b0);
    chk(o_irq_ack === 1'b1, "ack after shadow");
    quiet();
    i_irq = 8'h00;
    watch(10, 16'h02fd, s, x, v);
  endtask : t_return

  task automatic t_sleep;
    // a disable in the same cycle as a takeable request must win
    i_irq = 8'h02;
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b0);
    @(negedge i_clock);
    i_cli_exec = 1'b1;
    #1;
    chk(o_irq_ack === 1'b0, "ack beside disable");
    @(negedge i_clock);
    i_cli_exec  = 1'b0;
    i_insn_done = 1'b0;
    #1;
    chk(o_gie === 1'b0 && o_stall === 1'b0, "disable holds");
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b0);
    quiet();
    i_sleeping = 1'b1;
    i_irq      = 8'h04;
    quiet();
    chk(o_irq_ack === 1'b0, "ack before start-up");
    @(negedge i_clock);
    i_wake_ready = 1'b1;
    #1;
    chk(o_irq_ack === 1'b1, "wake ack");
    quiet();
    i_sleeping   = 1'b0;
    i_wake_ready = 1'b0;
    i_irq        = 8'h00;
    chk(o_irq_ack_vec === 8'h04, "wake grant");
    watch(14, 16'h02fd, s, x, v);
    chk(s == 11 && v == 8 && x == 2, "wake cycles");
  endtask : t_sleep

  task automatic t_ranges;
    @(negedge i_clock);
    i_nvm_addr        = 16'h01ff;
    i_flash_word_addr = 16'h1fff;
    #1;
    chk(o_nvm_addr_ok === 1'b1 && o_flash_addr_ok === 1'b1, "last ok");
    chk(o_store_pm_ok === 1'b1, "store at top");
    @(negedge i_clock);
    i_nvm_addr        = 16'h0200;
    i_flash_word_addr = 16'h2000;
    #1;
    chk(o_nvm_addr_ok === 1'b0 && o_flash_addr_ok === 1'b0, "beyond end");
    @(negedge i_clock);
    i_flash_word_addr = 16'h0000;
    #1;
    chk(o_store_pm_ok === 1'b1, "store at bottom");
  endtask : t_ranges
  // ************************************************************
  // control
  // ************************************************************
  task automatic finish_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // whole run is about a hundred cycles; 5000 leaves ample margin
  initial
  begin
    #50000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    n_mismatch = 0;
    tests_run  = 0;
    {i_resetn, i_insn_done, i_sleeping, i_wake_ready} = 4'h0;
    {i_sei_exec, i_cli_exec, i_reti_req} = 3'h0;
    {i_pc, i_sp, i_ptr_val, i_nvm_addr, i_flash_word_addr} = '0;
    i_irq  = 8'h00;
    i_dreq = '0;
    repeat (4) @(negedge i_clock);
    i_resetn = 1'b1;
    #1;
    chk(o_gie === 1'b0 && o_stall === 1'b0 && o_sram_rvalid === 1'b0, "reset state");
    t_decode();
    t_modes();
    t_sram();
    t_entry();
    t_return();
    t_sleep();
    t_ranges();
    finish_test();
  end
endmodule : tb
`default_nettype wire
